// File: src/lbbm_pkg.sv
package lbbm_pkg;
  localparam logic [7:0]  CTRL_OFFSET    = 8'h40;
  localparam int          CTRL_W         = 16;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] CTRL_WMASK     = 16'h0F7F;
  localparam int          CLKE_BIT       = 0;
  localparam int          ARBE_BIT       = 1;
  localparam int          RDY_LSB        = 2;
  localparam int          RDY_MSB        = 5;
  localparam int          NARROW_BIT     = 6;
  localparam int          HOLD_LSB       = 8;
  localparam int          HOLD_MSB       = 11;
  localparam logic [3:0]  RDY_EXTERNAL   = 4'h0;
  localparam logic [3:0]  RDY_MAX_CODE   = 4'hB;
  localparam logic [3:0]  READY_LIMIT    = 4'h9;
  localparam logic [4:0]  PCI_TIMEOUT    = 5'h10;
  localparam logic [20:0] HOLD_MARGIN    = 21'h00_0010;
  localparam int          HOLD_W         = 21;
  localparam int          SYNC_W         = 5;
  localparam int          S_LOCAL_CLOCK_OUT         = 0;
  localparam int          S_READY        = 1;
  localparam int          S_IRQ          = 2;
  localparam int          S_GRANT        = 3;
  localparam int          S_MODE         = 4;
  localparam int          CLR_ERR        = 0;
  localparam int          CLR_IRQ        = 1;
  localparam logic [1:0]  BE_LOW         = 2'h1;
  localparam logic [1:0]  BE_HIGH        = 2'h2;

  typedef enum logic [1:0] {X_IDLE, X_RUN} lbbm_xfer_t;
  typedef enum logic [1:0] {A_IDLE, A_REQ, A_OWN} lbbm_arb_t;
endpackage

// File: src/lbbm_bridge.sv
`timescale 1ns/1ns
module lbbm_bridge #(
  parameter int unsigned HOLD_BASE = 32
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        host_req,
  input  wire logic        host_write,
  input  wire logic [19:0] host_addr,
  input  wire logic [15:0] host_wdata,
  input  wire logic [1:0]  host_lane,
  input  wire logic        host_cfg_wr,
  input  wire logic [7:0]  host_cfg_offset,
  input  wire logic [15:0] host_cfg_wdata,
  input  wire logic        sw_reset,
  input  wire logic [1:0]  status_clear,
  input  wire logic        irq_mask_reg,
  input  wire logic        pci_config_select,
  input  wire logic        cfg_req,
  input  wire logic [19:0] cfg_addr_in,
  input  wire logic        cfg_byte,
  input  wire logic        bus_style_config,
  input  wire logic        local_clock_in,
  input  wire logic        external_ready_n,
  input  wire logic        local_irq_in_n,
  input  wire logic        bus_grant_in,
  input  wire logic [15:0] local_data_in,
  output logic             host_done,
  output logic             host_retry,
  output logic             host_abort,
  output logic [15:0]      host_rdata,
  output logic [15:0]      bridge_control_reg,
  output logic             local_error_flag,
  output logic             local_irq_flag,
  output logic             pci_irq_out_n,
  output logic             pci_config_select_gated,
  output logic [15:0]      cfg_addr_out,
  output logic             cfg_reject,
  output logic             local_clock_out,
  output logic             local_clock_oe_n,
  output logic [19:0]      local_address_bus,
  output logic [15:0]      local_data_out,
  output logic             local_data_oe_n,
  output logic             byte_high_enable_n,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic             local_bus_oe_n,
  output logic             bus_request_out,
  output logic             bus_owned_n,
  output logic             arb_pins_oe_n
);

  // hold timer word, wide enough for the largest hold field
  typedef logic [lbbm_pkg::HOLD_W-1:0] lbbm_hold_t;
  typedef struct packed {
    logic [lbbm_pkg::SYNC_W-1:0]  s1;
    logic [lbbm_pkg::SYNC_W-1:0]  s2;
    logic                         local_clock_out_prev;
    logic [lbbm_pkg::CTRL_W-1:0]  ctrl;
    lbbm_pkg::lbbm_xfer_t         xs;
    lbbm_pkg::lbbm_arb_t          as;
    logic [3:0]                   lcnt;
    logic [4:0]                   pcnt;
    logic [lbbm_pkg::HOLD_W-1:0]  hold;
    logic                         err;
    logic                         irqf;
    logic                         pirq_n;
    logic                         done;
    logic                         retry;
    logic                         abort;
    logic [15:0]                  rdata;
    logic                         idsel;
    logic [15:0]                  cfg_addr;
    logic                         cfg_rej;
    logic                         clk_out;
    logic                         clk_oe_n;
    logic [19:0]                  addr;
    logic [15:0]                  dout;
    logic                         dout_oe_n;
    logic                         bhe_n;
    logic                         rd_n;
    logic                         wr_n;
    logic                         bus_oe_n;
    logic                         req;
    logic                         owned_n;
    logic                         arb_oe_n;
  } lbbm_state_t;

  lbbm_state_t q;
  lbbm_state_t d;

  logic       cfg_mode;
  logic       local_clock_out_rise;
  logic       ready_seen;
  logic       grant_seen;
  logic       arbe;
  logic       narrow;
  logic [3:0] rdy_code;
  logic [3:0] hold_code;
  logic       ctrl_hit;

  assign cfg_mode   = q.s2[lbbm_pkg::S_MODE];
  assign local_clock_out_rise  = q.s2[lbbm_pkg::S_LOCAL_CLOCK_OUT] & ~q.local_clock_out_prev;
  assign ready_seen = ~q.s2[lbbm_pkg::S_READY];
  assign grant_seen = q.s2[lbbm_pkg::S_GRANT];
  // cfg mode masks the arbitration and narrow-bus enables, not the ready and hold codes
  assign arbe       = q.ctrl[lbbm_pkg::ARBE_BIT] & ~cfg_mode;
  assign narrow     = q.ctrl[lbbm_pkg::NARROW_BIT] & ~cfg_mode;
  assign rdy_code   = q.ctrl[lbbm_pkg::RDY_MSB:lbbm_pkg::RDY_LSB];
  assign hold_code  = q.ctrl[lbbm_pkg::HOLD_MSB:lbbm_pkg::HOLD_LSB];
  assign ctrl_hit   = host_cfg_offset == lbbm_pkg::CTRL_OFFSET;

  always_comb begin
    d = q;
    d.s1 = {bus_style_config, bus_grant_in, local_irq_in_n, external_ready_n, local_clock_in};
    d.s2 = q.s1;
    d.local_clock_out_prev = q.s2[lbbm_pkg::S_LOCAL_CLOCK_OUT];
    d.done = 1'b0;
    d.retry = 1'b0;
    d.abort = 1'b0;
    d.cfg_rej = 1'b0;

    if (host_cfg_wr && ctrl_hit && !cfg_mode) begin
      d.ctrl = host_cfg_wdata & lbbm_pkg::CTRL_WMASK;
    end

    // set wins over a clear in the same cycle
    d.err  = (q.err & ~status_clear[lbbm_pkg::CLR_ERR]) | 1'b0;
    d.irqf = (q.irqf & ~status_clear[lbbm_pkg::CLR_IRQ]) | (~q.s2[lbbm_pkg::S_IRQ] & ~cfg_mode);
    d.pirq_n = ~(q.irqf & ~irq_mask_reg);
    d.idsel = pci_config_select & ~cfg_mode;

    if (cfg_req && cfg_mode) begin
      d.cfg_addr = cfg_addr_in[15:0];
      d.cfg_rej = cfg_byte;
    end

    d.clk_out = q.s2[lbbm_pkg::S_LOCAL_CLOCK_OUT];
    d.clk_oe_n = ~(q.ctrl[lbbm_pkg::CLKE_BIT] & ~cfg_mode);
    d.arb_oe_n = ~arbe;

    case (q.xs)
      lbbm_pkg::X_IDLE: begin
        if (host_req) begin
          if (cfg_mode) begin
            d.abort = 1'b1;
          end else if (rdy_code > lbbm_pkg::RDY_MAX_CODE) begin
            d.abort = 1'b1;
          end else if (narrow && host_lane != lbbm_pkg::BE_LOW) begin
            d.abort = 1'b1;
          end else if (arbe && (q.as != lbbm_pkg::A_OWN || q.hold < lbbm_pkg::HOLD_MARGIN)) begin
            d.retry = 1'b1;
          end else begin
            d.xs = lbbm_pkg::X_RUN;
            d.lcnt = 4'h0;
            d.pcnt = 5'h00;
            d.addr = host_addr;
            d.dout = host_wdata;
            d.dout_oe_n = ~host_write;
            d.bhe_n = narrow | ~host_lane[1];
            d.rd_n = host_write;
            d.wr_n = ~host_write;
            d.bus_oe_n = 1'b0;
          end
        end
      end
      lbbm_pkg::X_RUN: begin
        if (q.pcnt != 5'h1F) begin
          d.pcnt = q.pcnt + 5'h01;
        end
        if (local_clock_out_rise) begin
          d.lcnt = q.lcnt + 4'h1;
        end
        if ((rdy_code == lbbm_pkg::RDY_EXTERNAL && ready_seen) ||
            (rdy_code != lbbm_pkg::RDY_EXTERNAL && local_clock_out_rise && q.lcnt + 4'h1 == rdy_code)) begin
          d.done = 1'b1;
          d.rdata = narrow ? {8'h00, local_data_in[7:0]} : local_data_in;
          d.xs = lbbm_pkg::X_IDLE;
        end else if (rdy_code == lbbm_pkg::RDY_EXTERNAL && q.lcnt >= lbbm_pkg::READY_LIMIT &&
                     q.pcnt >= lbbm_pkg::PCI_TIMEOUT) begin
          d.retry = 1'b1;
          d.err = 1'b1;
          d.xs = lbbm_pkg::X_IDLE;
        end
        if (d.xs == lbbm_pkg::X_IDLE) begin
          d.bus_oe_n = 1'b1;
          d.dout_oe_n = 1'b1;
          d.rd_n = 1'b1;
          d.wr_n = 1'b1;
          d.bhe_n = 1'b1;
        end
      end
      default: d.xs = lbbm_pkg::X_IDLE;
    endcase

    // hold timer only ticks on local clock edges, so it is coarse by one edge
    case (q.as)
      lbbm_pkg::A_IDLE: begin
        if (arbe && host_req && q.xs == lbbm_pkg::X_IDLE) begin
          d.req = 1'b1;
          d.as = lbbm_pkg::A_REQ;
        end
      end
      lbbm_pkg::A_REQ: begin
        if (grant_seen) begin
          d.owned_n = 1'b0;
          d.hold = lbbm_hold_t'(HOLD_BASE) << hold_code;
          d.as = lbbm_pkg::A_OWN;
        end
      end
      lbbm_pkg::A_OWN: begin
        if (local_clock_out_rise) begin
          if (q.hold <= 21'h00_0001) begin
            d.hold = '0;
            d.req = 1'b0;
            d.owned_n = 1'b1;
            d.as = lbbm_pkg::A_IDLE;
          end else begin
            d.hold = q.hold - 21'h00_0001;
          end
        end
      end
      default: d.as = lbbm_pkg::A_IDLE;
    endcase
    if (!arbe) begin
      d.as = lbbm_pkg::A_IDLE;
      d.req = 1'b0;
      d.owned_n = 1'b1;
      d.hold = '0;
    end

    // soft reset spares the control register
    if (sw_reset) begin
      d.err = 1'b0;
      d.irqf = 1'b0;
      d.xs = lbbm_pkg::X_IDLE;
      d.as = lbbm_pkg::A_IDLE;
      d.req = 1'b0;
      d.owned_n = 1'b1;
      d.bus_oe_n = 1'b1;
      d.dout_oe_n = 1'b1;
      d.rd_n = 1'b1;
      d.wr_n = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      // synchronisers start at idle pin levels, else ready and irq look asserted
      q.s1[lbbm_pkg::S_IRQ:lbbm_pkg::S_READY] <= 2'b11;
      q.s2[lbbm_pkg::S_IRQ:lbbm_pkg::S_READY] <= 2'b11;
      q.ctrl <= lbbm_pkg::CTRL_RESET;
      q.xs <= lbbm_pkg::X_IDLE;
      q.as <= lbbm_pkg::A_IDLE;
      q.pirq_n <= 1'b1;
      q.clk_oe_n <= 1'b1;
      q.dout_oe_n <= 1'b1;
      q.bhe_n <= 1'b1;
      q.rd_n <= 1'b1;
      q.wr_n <= 1'b1;
      q.bus_oe_n <= 1'b1;
      q.owned_n <= 1'b1;
      q.arb_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign host_done               = q.done;
  assign host_retry              = q.retry;
  assign host_abort              = q.abort;
  assign host_rdata              = q.rdata;
  assign bridge_control_reg      = q.ctrl;
  assign local_error_flag        = q.err;
  assign local_irq_flag          = q.irqf;
  assign pci_irq_out_n           = q.pirq_n;
  assign pci_config_select_gated = q.idsel;
  assign cfg_addr_out            = q.cfg_addr;
  assign cfg_reject              = q.cfg_rej;
  assign local_clock_out         = q.clk_out;
  assign local_clock_oe_n        = q.clk_oe_n;
  assign local_address_bus       = q.addr;
  assign local_data_out          = q.dout;
  assign local_data_oe_n         = q.dout_oe_n;
  assign byte_high_enable_n      = q.bhe_n;
  assign read_strobe_n           = q.rd_n;
  assign write_strobe_n          = q.wr_n;
  assign local_bus_oe_n          = q.bus_oe_n;
  assign bus_request_out         = q.req;
  assign bus_owned_n             = q.owned_n;
  assign arb_pins_oe_n           = q.arb_oe_n;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_req_granted;
    q.as == lbbm_pkg::A_REQ && grant_seen && arbe && !sw_reset;
  endsequence

  sequence s_ready_timeout;
    q.xs == lbbm_pkg::X_RUN && rdy_code == lbbm_pkg::RDY_EXTERNAL && !ready_seen &&
      q.lcnt >= lbbm_pkg::READY_LIMIT && q.pcnt >= lbbm_pkg::PCI_TIMEOUT && !sw_reset;
  endsequence

  a_timeout_error: assert property (s_ready_timeout |=> q.retry && q.err)
    else $error("ready timeout did not retry and flag error");

  a_timeout_bound: assert property (q.retry && $past(q.xs) == lbbm_pkg::X_RUN |-> $past(q.lcnt) >= 4'h9)
    else $error("retry came before nine local clocks");

  a_fixed_count: assert property (q.done && rdy_code != lbbm_pkg::RDY_EXTERNAL |-> $past(q.lcnt) + 4'h1 == rdy_code)
    else $error("fixed transfer ended at wrong local clock");

  a_idsel_block: assert property (cfg_mode |=> !q.idsel)
    else $error("config select passed in configuration mode");

  a_cfg_no_data: assert property (cfg_mode && host_req && q.xs == lbbm_pkg::X_IDLE |=> q.abort && !q.done)
    else $error("host access served in configuration mode");

  a_ctrl_locked: assert property (cfg_mode |=> $stable(q.ctrl))
    else $error("control register changed in configuration mode");

  a_arb_off: assert property (!arbe |=> q.owned_n && !q.req && q.arb_oe_n)
    else $error("arbitration pins active while disabled");

  a_grant_own: assert property (s_req_granted |=> !q.owned_n ##0 q.hold == lbbm_hold_t'(HOLD_BASE) << hold_code)
    else $error("grant did not take the bus with programmed hold");

  a_irq_gate: assert property (q.pirq_n == !($past(q.irqf) && !$past(irq_mask_reg)))
    else $error("pci interrupt does not follow masked flag");

  a_err_sticky: assert property (q.err && !status_clear[lbbm_pkg::CLR_ERR] && !sw_reset |=> q.err)
    else $error("error flag dropped without a clear");

  a_unowned_retry: assert property (host_req && q.xs == lbbm_pkg::X_IDLE && !cfg_mode && arbe &&
                                    q.as != lbbm_pkg::A_OWN && rdy_code <= lbbm_pkg::RDY_MAX_CODE &&
                                    !(narrow && host_lane != lbbm_pkg::BE_LOW) |=> q.retry && q.bus_oe_n)
    else $error("unowned access not retried with bus tristated");

  a_clock_pin: assert property (!q.ctrl[lbbm_pkg::CLKE_BIT] |=> q.clk_oe_n)
    else $error("local clock driven while disabled");

endmodule // lbbm_bridge

// File: bench/lbbm_peer.sv
`timescale 1ns/1ns
module lbbm_peer (
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic        bus_request_out,
  input  wire logic        arb_pins_oe_n,
  input  wire logic [31:0] ready_after,
  output logic             local_clock_in,
  output logic             external_ready_n,
  output logic             bus_grant_in,
  output logic [15:0]      local_data_in
);
  int   rises = 0;
  logic active;
  initial begin
    local_clock_in = 1'b0;
    bus_grant_in = 1'b0;
  end
  // a bus clock runs free
  always #400 local_clock_in = ~local_clock_in;
  // released data shows the inverse, so a late sample reads wrong
  assign local_data_in = !read_strobe_n ? 16'hC3A5 : 16'h3C5A;
  assign active = !read_strobe_n || !write_strobe_n;
  // count restarts as the strobes rise, so no stale ready meets the next access
  always @(posedge local_clock_in or negedge active) begin
    rises <= active ? rises + 1 : 0;
  end
  // ready_after of 0 models a peripheral that never answers
  assign external_ready_n = !(active && ready_after != 0 && rises >= ready_after);
  always @(posedge local_clock_in) begin
    bus_grant_in <= bus_request_out && !arb_pins_oe_n;
  end
endmodule // lbbm_peer

// File: bench/local_bus_bridge_master_test.sv
`timescale 1ns/1ns
module local_bus_bridge_master_test;
  logic        clk_sys, reset_n, host_req, host_write, host_cfg_wr, sw_reset, irq_mask_reg;
  logic        pci_config_select, cfg_req, cfg_byte, bus_style_config, local_irq_in_n;
  logic        host_done, host_retry, host_abort, local_error_flag, local_irq_flag, pci_irq_out_n;
  logic        pci_config_select_gated, cfg_reject, local_clock_out, local_clock_oe_n, local_data_oe_n;
  logic        byte_high_enable_n, read_strobe_n, write_strobe_n, local_bus_oe_n, bus_request_out;
  logic        bus_owned_n, arb_pins_oe_n, local_clock_in, external_ready_n, bus_grant_in, rej;
  logic [19:0] host_addr, cfg_addr_in, local_address_bus;
  logic [15:0] host_wdata, host_cfg_wdata, host_rdata, bridge_control_reg, cfg_addr_out;
  logic [15:0] local_data_in, local_data_out, model_ctrl;
  logic [7:0]  host_cfg_offset;
  logic [1:0]  host_lane, status_clear;
  int          bad_count, cmp_count, seed, ready_after, n, t;
  time         tm;

  lbbm_bridge #(.HOLD_BASE(32)) lbbm_bridge_i (.*);
  lbbm_peer lbbm_peer_i (.*);

  always #50 clk_sys = ~clk_sys;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask

  task automatic cfg_wr(input logic [7:0] off, input logic [15:0] d);
    @(negedge clk_sys);
    host_cfg_wr = 1'b1;
    host_cfg_offset = off;
    host_cfg_wdata = d;
    if (off == lbbm_pkg::CTRL_OFFSET && !bus_style_config) model_ctrl = d & lbbm_pkg::CTRL_WMASK;
    tick(1);
    host_cfg_wr = 1'b0;
    tick(1);
  endtask

  // reference of the answer kind: 0 done, 1 retry, 2 abort
  function automatic int kind(input logic [1:0] ln, input bit owned);
    if (bus_style_config || model_ctrl[5:2] > 4'hB) return 2;
    if (model_ctrl[6] && ln != 2'b01) return 2;
    if (model_ctrl[1] && !owned) return 1;
    if (model_ctrl[5:2] == 4'h0 && ready_after == 0) return 1;
    return 0;
  endfunction

  task automatic access(input logic [1:0] ln, input int k);
    int got;
    @(negedge clk_sys);
    host_req = 1'b1;
    host_write = 1'($random(seed));
    host_addr = 20'($random(seed));
    host_wdata = 16'($random(seed));
    host_lane = ln;
    tick(1);
    host_req = 1'b0;
    if (k == 0) begin
      chk(local_address_bus[15:0], host_addr[15:0], "address driven");
      chk({12'h0, local_address_bus[19:16]}, {12'h0, host_addr[19:16]}, "upper address driven");
      chk({13'h0, local_bus_oe_n, read_strobe_n, write_strobe_n}, {13'h0, 1'b0, host_write, !host_write}, "strobes");
      chk({14'h0, local_data_oe_n, byte_high_enable_n}, {14'h0, !host_write, model_ctrl[6] || !ln[1]}, "lanes");
      if (host_write) chk(local_data_out, host_wdata, "write data");
    end
    got = 3;
    for (t = 1; t < 200 && got == 3; t++) begin
      if (host_done === 1'b1) got = 0;
      else if (host_retry === 1'b1) got = 1;
      else if (host_abort === 1'b1) got = 2;
      else tick(1);
    end
    if (got == 3) begin
      bad_count++;
      wrap_up();
    end
    chk(16'(got), 16'(k), "answer kind");
    if (got == 0 && !host_write) chk(host_rdata, model_ctrl[6] ? 16'h00A5 : 16'hC3A5, "read data");
  endtask

  task automatic wait_owned(input logic v, input int bus_style_select);
    for (t = 0; t < bus_style_select && bus_owned_n !== v; t++) tick(1);
    if (t == bus_style_select) begin
      bad_count++;
      wrap_up();
    end
  endtask

  initial begin
    #10_000_000;
    bad_count++;
    wrap_up();
  end

  initial begin
    {clk_sys, reset_n, host_req, host_write, host_cfg_wr, sw_reset, irq_mask_reg} = '0;
    {pci_config_select, cfg_req, cfg_byte, bus_style_config} = '0;
    {host_addr, cfg_addr_in, host_wdata, host_cfg_wdata, host_cfg_offset, host_lane, status_clear} = '0;
    local_irq_in_n = 1'b1;
    seed = 66;
    ready_after = 2;
    model_ctrl = 16'h0000;
    tick(3);
    reset_n = 1'b1;
    tick(3);
    chk(bridge_control_reg, 16'h0000, "control reset");
    chk({15'h0, local_clock_oe_n}, 16'h0001, "clock pin tristated");
    cfg_wr(8'h44, 16'h0001);
    chk(bridge_control_reg, 16'h0000, "other offset");
    cfg_wr(lbbm_pkg::CTRL_OFFSET, 16'hFFFF);
    chk(bridge_control_reg, model_ctrl, "control mask");
    tend("registers");
    for (n = 1; n < 16; n++) begin
      cfg_wr(lbbm_pkg::CTRL_OFFSET, 16'h0001 | 16'(n << 2));
      access(2'b11, kind(2'b11, 0));
      if (n < 12) chk({15'h0, t > 8 * n - 8 && t < 8 * n + 6}, 16'h0001, "transfer length");
    end
    chk({14'h0, bus_request_out, arb_pins_oe_n}, 16'h0001, "arbitration pins off");
    chk({15'h0, local_clock_oe_n}, 16'h0000, "clock pin driven");
    repeat (2) begin
      @(posedge clk_sys);
      rej = local_clock_in;
      tick(3);
      chk({15'h0, local_clock_out}, {15'h0, rej}, "local clock out");
      tick(1);
    end
    tend("timing codes");
    cfg_wr(lbbm_pkg::CTRL_OFFSET, 16'h0045);
    access(2'b11, kind(2'b11, 0));
    access(2'b01, kind(2'b01, 0));
    tend("narrow bus");
    cfg_wr(lbbm_pkg::CTRL_OFFSET, 16'h0001);
    for (n = 0; n < 3; n++) begin
      ready_after = (n == 2) ? 0 : 3 + 5 * n;
      access(2'b11, kind(2'b11, 0));
      chk({15'h0, local_error_flag}, {15'h0, n == 2}, "error flag");
    end
    tick(20);
    chk({15'h0, local_error_flag}, 16'h0001, "error flag sticky");
    status_clear = 2'b01;
    tick(1);
    status_clear = 2'b00;
    tick(1);
    chk({15'h0, local_error_flag}, 16'h0000, "error flag cleared");
    ready_after = 2;
    tend("ready timing");
    local_irq_in_n = 1'b0;
    tick(4);
    local_irq_in_n = 1'b1;
    tick(2);
    chk({14'h0, local_irq_flag, pci_irq_out_n}, 16'h0002, "irq raised");
    irq_mask_reg = 1'b1;
    tick(2);
    chk({15'h0, pci_irq_out_n}, 16'h0001, "irq masked");
    status_clear = 2'b10;
    tick(1);
    status_clear = 2'b00;
    tick(1);
    chk({15'h0, local_irq_flag}, 16'h0000, "irq cleared");
    tend("interrupt");
    // the hold timer runs in local clocks, so the window is wide
    cfg_wr(lbbm_pkg::CTRL_OFFSET, 16'h0007);
    access(2'b11, kind(2'b11, 0));
    chk({14'h0, arb_pins_oe_n, local_bus_oe_n}, 16'h0001, "bus tristated, arbitration pins on");
    wait_owned(1'b0, 100);
    tm = $time;
    access(2'b11, kind(2'b11, 1));
    tick(150);
    access(2'b11, 1);
    wait_owned(1'b1, 300);
    n = int'(($time - tm) / 100);
    chk({15'h0, n > 232 && n < 266}, 16'h0001, "hold length");
    tick(12);
    chk({15'h0, bus_request_out}, 16'h0000, "request released");
    tend("arbitration");
    bus_style_config = 1'b1;
    pci_config_select = 1'b1;
    tick(4);
    chk({15'h0, pci_config_select_gated}, 16'h0000, "select ignored");
    access(2'b11, kind(2'b11, 0));
    chk({15'h0, bus_request_out}, 16'h0000, "no arbitration");
    cfg_wr(lbbm_pkg::CTRL_OFFSET, 16'h0000);
    chk(bridge_control_reg, model_ctrl, "control locked");
    cfg_addr_in = 20'hF_1234;
    cfg_req = 1'b1;
    tick(1);
    cfg_req = 1'b0;
    tick(2);
    chk(cfg_addr_out, 16'h1234, "config address");
    cfg_byte = 1'b1;
    cfg_req = 1'b1;
    tick(1);
    cfg_req = 1'b0;
    rej = 1'b0;
    repeat (3) begin
      rej = rej | cfg_reject;
      tick(1);
    end
    chk({15'h0, rej}, 16'h0001, "byte access rejected");
    bus_style_config = 1'b0;
    cfg_byte = 1'b0;
    tick(4);
    chk({15'h0, pci_config_select_gated}, 16'h0001, "select passed");
    sw_reset = 1'b1;
    tick(1);
    sw_reset = 1'b0;
    tick(2);
    chk(bridge_control_reg, model_ctrl, "control kept");
    tend("configuration mode");
    wrap_up();
  end
endmodule // local_bus_bridge_master_test
